// File: tcc_client.sv
`timescale 1ns/1ps
// Functional notes
// - Request starts with seven-byte transport header.
// - Accept responses only with protocol id zero.
// - No duplicate open transaction identifiers.
// - Identifiers come from an incrementing counter.
// - Pipelined requests, capped by configured maximum.
// - Direct server target uses unit 0xFF.
// - Gateway unit carries serial address, 0..247.
// - Unmatched transaction identifier: drop silently.
// - Matched response yields exactly one confirmation.
// - Length field sizes the remaining response.
// - Unit 0xFF response: responder is connection.
// - Other unit value names serial server.
// - Same function code, good format: positive.
// - Function code plus 80H: positive, exception.
// - Other code or bad format: negative.
// - Response timeout is configurable.
// - Timeout expiry gives negative confirmation.
module tcc_client import tcc_pkg::*; #(
	parameter int NSLOT = TCC_MAX_TXN,
	parameter int IW = $clog2(NSLOT)
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Configuration.
	input wire logic [4:0] max_open_client_transactions,
	input wire logic [31:0] timeout_cycles,
	// Demand from the user application, PDU bytes with side information.
	input wire logic dem_valid,
	output logic dem_ready,
	input wire logic [7:0] dem_data,
	input wire logic dem_last,
	input wire logic [7:0] dem_pdu_len,
	input wire logic dem_via_gateway,
	input wire logic [7:0] dem_serial_addr,
	output logic dem_error,
	// Request stream to TCP management.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last,
	// Response stream from TCP management.
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	// Response PDU data to the user application.
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	// Confirmations to the user application.
	output logic cnf_valid,
	output logic cnf_positive,
	output logic cnf_exception,
	output logic cnf_timeout,
	output logic [15:0] cnf_tid,
	output logic [7:0] cnf_fc,
	output logic [7:0] cnf_unit,
	output logic cnf_from_serial,
	// Status.
	output logic [IW:0] open_count
);

	typedef struct packed {
		tcc_tx_e tx_st;
		logic [2:0] hidx;
		logic [15:0] tid_ctr;
		logic [15:0] cur_tid;
		logic [15:0] cur_len;
		logic [7:0] cur_unit;
		logic o_valid;
		logic [7:0] o_data;
		logic o_last;
		logic dem_err;
		tcc_rx_e rx_st;
		logic [2:0] ridx;
		logic [15:0] r_tid;
		logic [15:0] r_proto;
		logic [15:0] r_len;
		logic [7:0] r_unit;
		logic [IW-1:0] r_slot;
		logic [7:0] r_fc_req;
		logic r_exc;
		logic r_held;
		logic [15:0] rem;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic cnf_valid;
		logic cnf_pos;
		logic cnf_exc;
		logic cnf_tmo;
		logic [15:0] cnf_tid;
		logic [7:0] cnf_fc;
		logic [7:0] cnf_unit;
		logic cnf_serial;
	} tcc_client_s;

	tcc_client_s st_r;
	tcc_client_s st_nxt;

	logic alloc;
	logic cand_busy;
	logic can_alloc;
	logic look_hit;
	logic [IW-1:0] look_slot;
	logic [7:0] look_fc;
	logic free;
	logic [IW-1:0] free_slot;
	logic exp_any;
	logic [IW-1:0] exp_slot;
	logic [15:0] exp_tid;
	logic [7:0] exp_fc;
	logic load_ok;
	logic unit_ok;
	logic rx_cnf;
	logic rx_pos;
	logic fc_exc;
	logic fc_norm;
	logic [IW-1:0] cslot;
	logic [7:0] cfc;

	// Transaction slots with identifiers, request codes and timers.
	tcc_slot_table #(
		.NSLOT(NSLOT),
		.IW(IW)
	) u_slots (
		.clk_sys(clk_sys),
		.rst(rst),
		.max_open(max_open_client_transactions),
		.timeout_cycles(timeout_cycles),
		.alloc(alloc),
		.alloc_tid(st_r.tid_ctr),
		.alloc_fc(dem_data),
		.cand_tid(st_r.tid_ctr),
		.cand_busy(cand_busy),
		.can_alloc(can_alloc),
		.look_tid(st_r.r_tid),
		.look_hit(look_hit),
		.look_slot(look_slot),
		.look_fc(look_fc),
		.free(free),
		.free_slot(free_slot),
		.exp_any(exp_any),
		.exp_slot(exp_slot),
		.exp_tid(exp_tid),
		.exp_fc(exp_fc),
		.open_cnt(open_count)
	);

	// Gateway addresses above the serial range are refused; zero is broadcast.
	assign unit_ok = !dem_via_gateway || (dem_serial_addr <= TCC_SERIAL_ADDR_MAX);

	// Output byte register: a new byte loads when it is empty or being taken.
	assign load_ok = !st_r.o_valid || tx_ready;

	// Request sequencer, response parser and confirmation arbiter.
	always_comb begin
		st_nxt = st_r;
		st_nxt.dem_err = 1'b0;
		st_nxt.rsp_valid = 1'b0;
		st_nxt.cnf_valid = 1'b0;
		alloc = 1'b0;
		free = 1'b0;
		free_slot = '0;
		dem_ready = 1'b0;
		rx_cnf = 1'b0;
		rx_pos = 1'b0;
		fc_exc = 1'b0;
		fc_norm = 1'b0;
		cslot = st_r.r_slot;
		cfc = st_r.r_fc_req;
		if (st_r.o_valid && tx_ready) begin
			st_nxt.o_valid = 1'b0;
		end

		case (st_r.tx_st)
			TCC_TX_IDLE: begin
				if (dem_valid && !unit_ok) begin
					st_nxt.dem_err = 1'b1;
					st_nxt.tx_st = TCC_TX_REJ;
				end else if (dem_valid && cand_busy) begin
					// Skip a value still held by an old open transaction.
					st_nxt.tid_ctr = st_r.tid_ctr + TCC_TID_STEP;
				end else if (dem_valid && can_alloc) begin
					alloc = 1'b1;
					st_nxt.cur_tid = st_r.tid_ctr;
					st_nxt.tid_ctr = st_r.tid_ctr + TCC_TID_STEP;
					st_nxt.cur_len = {8'h00, dem_pdu_len} + TCC_LEN_UNIT;
					st_nxt.cur_unit = dem_via_gateway ? dem_serial_addr : TCC_UNIT_DIRECT;
					st_nxt.hidx = TCC_HB_TID_HI;
					st_nxt.tx_st = TCC_TX_HDR;
				end
			end
			TCC_TX_HDR: begin
				if (load_ok) begin
					st_nxt.o_valid = 1'b1;
					st_nxt.o_last = 1'b0;
					// Header bytes go out most significant byte first.
					case (st_r.hidx)
						TCC_HB_TID_HI: st_nxt.o_data = st_r.cur_tid[15:8];
						TCC_HB_TID_LO: st_nxt.o_data = st_r.cur_tid[7:0];
						TCC_HB_PROTO_HI: st_nxt.o_data = TCC_PROTO_ID[15:8];
						TCC_HB_PROTO_LO: st_nxt.o_data = TCC_PROTO_ID[7:0];
						TCC_HB_LEN_HI: st_nxt.o_data = st_r.cur_len[15:8];
						TCC_HB_LEN_LO: st_nxt.o_data = st_r.cur_len[7:0];
						default: st_nxt.o_data = st_r.cur_unit;
					endcase
					st_nxt.hidx = st_r.hidx + 3'h1;
					if (st_r.hidx == TCC_HB_UNIT) begin
						st_nxt.tx_st = TCC_TX_PDU;
					end
				end
			end
			TCC_TX_PDU: begin
				dem_ready = load_ok;
				if (dem_valid && load_ok) begin
					st_nxt.o_valid = 1'b1;
					st_nxt.o_data = dem_data;
					st_nxt.o_last = dem_last;
					if (dem_last) begin
						st_nxt.tx_st = TCC_TX_IDLE;
					end
				end
			end
			TCC_TX_REJ: begin
				// A refused demand is drained so the user stream stays aligned.
				dem_ready = 1'b1;
				if (dem_valid && dem_last) begin
					st_nxt.tx_st = TCC_TX_IDLE;
				end
			end
			default: begin
				st_nxt.tx_st = TCC_TX_IDLE;
			end
		endcase

		if (rx_valid) begin
			case (st_r.rx_st)
				TCC_RX_HDR: begin
					case (st_r.ridx)
						TCC_HB_TID_HI: st_nxt.r_tid[15:8] = rx_data;
						TCC_HB_TID_LO: st_nxt.r_tid[7:0] = rx_data;
						TCC_HB_PROTO_HI: st_nxt.r_proto[15:8] = rx_data;
						TCC_HB_PROTO_LO: st_nxt.r_proto[7:0] = rx_data;
						TCC_HB_LEN_HI: st_nxt.r_len[15:8] = rx_data;
						TCC_HB_LEN_LO: st_nxt.r_len[7:0] = rx_data;
						default: st_nxt.r_unit = rx_data;
					endcase
					st_nxt.ridx = st_r.ridx + 3'h1;
					if (st_r.ridx == TCC_HB_UNIT) begin
						st_nxt.ridx = TCC_HB_TID_HI;
						if ((st_r.r_proto != TCC_PROTO_ID) || !look_hit) begin
							st_nxt.rx_st = rx_last ? TCC_RX_HDR : TCC_RX_SKIP;
						end else begin
							cslot = look_slot;
							cfc = look_fc;
							st_nxt.r_slot = look_slot;
							st_nxt.r_fc_req = look_fc;
							st_nxt.r_exc = 1'b0;
							st_nxt.r_held = 1'b1;
							st_nxt.rem = st_r.r_len - TCC_LEN_UNIT;
							if (rx_last || (st_r.r_len < TCC_LEN_MIN_RSP)) begin
								rx_cnf = 1'b1;
							end else begin
								st_nxt.rx_st = TCC_RX_FC;
							end
						end
					end else if (rx_last) begin
						st_nxt.ridx = TCC_HB_TID_HI;
					end
				end
				TCC_RX_FC: begin
					fc_norm = (rx_data == st_r.r_fc_req);
					fc_exc = (rx_data == (st_r.r_fc_req | TCC_EXC_FLAG));
					st_nxt.r_exc = fc_exc;
					st_nxt.rem = st_r.rem - TCC_REM_LAST;
					if (!fc_norm && !fc_exc) begin
						rx_cnf = 1'b1;
					end else if (fc_exc && (st_r.rem != (TCC_LEN_EXC - TCC_LEN_UNIT))) begin
						rx_cnf = 1'b1;
					end else if (st_r.rem == TCC_REM_LAST) begin
						rx_cnf = 1'b1;
						rx_pos = rx_last;
					end else if (rx_last) begin
						rx_cnf = 1'b1;
					end else begin
						st_nxt.rx_st = TCC_RX_BODY;
					end
				end
				TCC_RX_BODY: begin
					st_nxt.rsp_valid = 1'b1;
					st_nxt.rsp_data = rx_data;
					st_nxt.rem = st_r.rem - TCC_REM_LAST;
					// The frame must end exactly where the length field says.
					if (st_r.rem == TCC_REM_LAST) begin
						rx_cnf = 1'b1;
						rx_pos = rx_last;
					end else if (rx_last) begin
						rx_cnf = 1'b1;
					end
				end
				TCC_RX_SKIP: begin
					if (rx_last) begin
						st_nxt.rx_st = TCC_RX_HDR;
					end
				end
				default: begin
					st_nxt.rx_st = TCC_RX_HDR;
				end
			endcase
		end

		// A parser confirmation wins; an expiry also waits while its slot is being parsed.
		if (rx_cnf) begin
			st_nxt.rx_st = rx_last ? TCC_RX_HDR : TCC_RX_SKIP;
			st_nxt.r_held = 1'b0;
			st_nxt.cnf_valid = 1'b1;
			st_nxt.cnf_pos = rx_pos;
			st_nxt.cnf_exc = rx_pos && st_nxt.r_exc;
			st_nxt.cnf_tmo = 1'b0;
			st_nxt.cnf_tid = st_r.r_tid;
			st_nxt.cnf_fc = cfc;
			st_nxt.cnf_unit = st_r.r_unit;
			st_nxt.cnf_serial = (st_r.r_unit != TCC_UNIT_DIRECT);
			free = 1'b1;
			free_slot = cslot;
		end else if (exp_any && !(st_r.r_held && (st_r.r_slot == exp_slot))) begin
			st_nxt.cnf_valid = 1'b1;
			st_nxt.cnf_pos = 1'b0;
			st_nxt.cnf_exc = 1'b0;
			st_nxt.cnf_tmo = 1'b1;
			st_nxt.cnf_tid = exp_tid;
			st_nxt.cnf_fc = exp_fc;
			st_nxt.cnf_unit = TCC_UNIT_DIRECT;
			st_nxt.cnf_serial = 1'b0;
			free = 1'b1;
			free_slot = exp_slot;
		end
	end

	// State register.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// The parser never stalls the response stream.
	assign rx_ready = 1'b1;
	assign dem_error = st_r.dem_err;
	assign tx_valid = st_r.o_valid;
	assign tx_data = st_r.o_data;
	assign tx_last = st_r.o_last;
	assign rsp_valid = st_r.rsp_valid;
	assign rsp_data = st_r.rsp_data;
	assign cnf_valid = st_r.cnf_valid;
	assign cnf_positive = st_r.cnf_pos;
	assign cnf_exception = st_r.cnf_exc;
	assign cnf_timeout = st_r.cnf_tmo;
	assign cnf_tid = st_r.cnf_tid;
	assign cnf_fc = st_r.cnf_fc;
	assign cnf_unit = st_r.cnf_unit;
	assign cnf_from_serial = st_r.cnf_serial;

endmodule

// File: tcc_pkg.sv
package tcc_pkg;

	// Frame layout of the application transport header.
	localparam int TCC_HDR_BYTES = 7;
	localparam int TCC_MAX_TXN = 16;
	localparam logic [2:0] TCC_HB_TID_HI = 3'h0;
	localparam logic [2:0] TCC_HB_TID_LO = 3'h1;
	localparam logic [2:0] TCC_HB_PROTO_HI = 3'h2;
	localparam logic [2:0] TCC_HB_PROTO_LO = 3'h3;
	localparam logic [2:0] TCC_HB_LEN_HI = 3'h4;
	localparam logic [2:0] TCC_HB_LEN_LO = 3'h5;
	localparam logic [2:0] TCC_HB_UNIT = 3'h6;

	// Field values.
	localparam logic [15:0] TCC_PROTO_ID = 16'h0000;
	localparam logic [7:0] TCC_UNIT_DIRECT = 8'hFF;
	localparam logic [7:0] TCC_SERIAL_ADDR_MAX = 8'hF7;
	localparam logic [7:0] TCC_EXC_FLAG = 8'h80;

	// Length arithmetic: the length field counts the unit byte plus the PDU.
	localparam logic [15:0] TCC_LEN_UNIT = 16'h0001;
	localparam logic [15:0] TCC_LEN_MIN_RSP = 16'h0002;
	localparam logic [15:0] TCC_LEN_EXC = 16'h0003;
	localparam logic [15:0] TCC_REM_LAST = 16'h0001;
	localparam logic [15:0] TCC_TID_STEP = 16'h0001;
	localparam logic [31:0] TCC_TMO_MIN = 32'h0000_0001;

	// Request side sequencer.
	typedef enum logic [1:0] {
		TCC_TX_IDLE = 2'b00,
		TCC_TX_HDR = 2'b01,
		TCC_TX_PDU = 2'b10,
		TCC_TX_REJ = 2'b11
	} tcc_tx_e;

	// Response side parser.
	typedef enum logic [1:0] {
		TCC_RX_HDR = 2'b00,
		TCC_RX_FC = 2'b01,
		TCC_RX_BODY = 2'b10,
		TCC_RX_SKIP = 2'b11
	} tcc_rx_e;

endpackage

// File: tcc_slot_table.sv
`timescale 1ns/1ps
module tcc_slot_table import tcc_pkg::*; #(
	parameter int NSLOT = TCC_MAX_TXN,
	parameter int IW = $clog2(NSLOT)
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Configuration.
	input wire logic [4:0] max_open,
	input wire logic [31:0] timeout_cycles,
	// Allocation.
	input wire logic alloc,
	input wire logic [15:0] alloc_tid,
	input wire logic [7:0] alloc_fc,
	input wire logic [15:0] cand_tid,
	output logic cand_busy,
	output logic can_alloc,
	// Lookup for responses.
	input wire logic [15:0] look_tid,
	output logic look_hit,
	output logic [IW-1:0] look_slot,
	output logic [7:0] look_fc,
	// Release.
	input wire logic free,
	input wire logic [IW-1:0] free_slot,
	// Expired transactions.
	output logic exp_any,
	output logic [IW-1:0] exp_slot,
	output logic [15:0] exp_tid,
	output logic [7:0] exp_fc,
	output logic [IW:0] open_cnt
);

	typedef struct packed {
		logic [NSLOT-1:0] valid;
		logic [NSLOT-1:0] expd;
		logic [NSLOT-1:0][15:0] tid;
		logic [NSLOT-1:0][7:0] fc;
		logic [NSLOT-1:0][31:0] tmr;
	} tcc_slot_s;

	tcc_slot_s st_r;
	tcc_slot_s st_nxt;
	logic [NSLOT-1:0] hit_v;
	logic [NSLOT-1:0] busy_v;
	logic [NSLOT-1:0] exp_v;
	logic [IW-1:0] free_idx;
	logic any_free;
	logic [4:0] max_eff;

	// Per-slot match vectors; expired slots no longer answer a lookup.
	for (genvar g = 0; g < NSLOT; g++) begin : g_slot
		assign hit_v[g] = st_r.valid[g] & ~st_r.expd[g] & (st_r.tid[g] == look_tid);
		assign busy_v[g] = st_r.valid[g] & (st_r.tid[g] == cand_tid);
		assign exp_v[g] = st_r.valid[g] & st_r.expd[g];
	end

	// Clamp the configured ceiling into the legal one to NSLOT range.
	always_comb begin
		if (max_open == 5'h00) begin
			max_eff = 5'h01;
		end else if (32'(max_open) > NSLOT) begin
			max_eff = 5'(NSLOT);
		end else begin
			max_eff = max_open;
		end
	end

	// Priority encoders, occupancy count and the slot update.
	always_comb begin
		st_nxt = st_r;
		look_slot = '0;
		exp_slot = '0;
		free_idx = '0;
		any_free = 1'b0;
		open_cnt = '0;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (hit_v[i]) begin
				look_slot = IW'(i);
			end
			if (exp_v[i]) begin
				exp_slot = IW'(i);
			end
			if (!st_r.valid[i]) begin
				free_idx = IW'(i);
				any_free = 1'b1;
			end
		end
		for (int i = 0; i < NSLOT; i++) begin
			open_cnt = open_cnt + (IW + 1)'(st_r.valid[i]);
			// Timers run down only while the slot is open and not yet expired.
			if (st_r.valid[i] && !st_r.expd[i]) begin
				if (st_r.tmr[i] <= TCC_TMO_MIN) begin
					st_nxt.expd[i] = 1'b1;
				end
				st_nxt.tmr[i] = st_r.tmr[i] - TCC_TMO_MIN;
			end
		end
		if (free) begin
			st_nxt.valid[free_slot] = 1'b0;
			st_nxt.expd[free_slot] = 1'b0;
		end
		if (alloc) begin
			st_nxt.valid[free_idx] = 1'b1;
			st_nxt.expd[free_idx] = 1'b0;
			st_nxt.tid[free_idx] = alloc_tid;
			st_nxt.fc[free_idx] = alloc_fc;
			st_nxt.tmr[free_idx] = (timeout_cycles < TCC_TMO_MIN) ? TCC_TMO_MIN : timeout_cycles;
		end
	end

	assign cand_busy = |busy_v;
	assign can_alloc = any_free && (open_cnt < (IW + 1)'(max_eff));
	assign look_hit = |hit_v;
	assign look_fc = st_r.fc[look_slot];
	assign exp_any = |exp_v;
	assign exp_tid = st_r.tid[exp_slot];
	assign exp_fc = st_r.fc[exp_slot];

	// State register.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

// File: tcc_client_assertions.sv
`timescale 1ns/1ps
module tcc_client_assertions import tcc_pkg::*; #(
	parameter int NSLOT = TCC_MAX_TXN,
	parameter int IW = $clog2(NSLOT)
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Request side.
	input wire logic [4:0] max_open_client_transactions,
	input wire logic dem_error,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic rx_ready,
	// Confirmation side.
	input wire logic cnf_valid,
	input wire logic cnf_positive,
	input wire logic cnf_exception,
	input wire logic cnf_timeout,
	input wire logic [7:0] cnf_unit,
	input wire logic cnf_from_serial,
	input wire logic [IW:0] open_count
);
	logic [2:0] idx_r;
	logic [5:0] cap;

	// Byte position in the outgoing frame; parks at 7 so long PDUs cannot wrap into the header range.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			idx_r <= 3'h0;
		end else if (tx_valid && tx_ready) begin
			idx_r <= tx_last ? 3'h0 : (idx_r == 3'h7 ? 3'h7 : idx_r + 3'h1);
		end
	end

	// Effective limit; a zero setting still allows one open transaction.
	assign cap = (max_open_client_transactions == 5'h00) ? 6'h01 :
		((max_open_client_transactions > NSLOT) ? 6'(NSLOT) : {1'b0, max_open_client_transactions});

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed while stalled");
	property p_proto;
		tx_valid && (idx_r == 3'h2 || idx_r == 3'h3) |-> tx_data == 8'h00;
	endproperty
	a_proto: assert property (p_proto) else $error("protocol bytes not zero");
	property p_hdr_whole;
		tx_valid && idx_r < 3'h7 |-> !tx_last;
	endproperty
	a_hdr_whole: assert property (p_hdr_whole) else $error("frame ended inside header");
	property p_unit;
		tx_valid && idx_r == 3'h6 |-> tx_data == 8'hFF || tx_data <= 8'hF7;
	endproperty
	a_unit: assert property (p_unit) else $error("unit byte out of range");
	property p_cap;
		open_count <= cap;
	endproperty
	a_cap: assert property (p_cap) else $error("too many open transactions");
	property p_exc;
		cnf_valid && cnf_exception |-> cnf_positive && !cnf_timeout;
	endproperty
	a_exc: assert property (p_exc) else $error("exception not positive");
	property p_tmo;
		cnf_valid && cnf_timeout |-> !cnf_positive && !cnf_exception && cnf_unit == 8'hFF && !cnf_from_serial;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout confirmation malformed");
	property p_serial;
		cnf_valid && !cnf_timeout |-> cnf_from_serial == (cnf_unit != 8'hFF);
	endproperty
	a_serial: assert property (p_serial) else $error("serial flag disagrees with unit");
	property p_rx_ready;
		1'b1 |-> rx_ready;
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("responses back-pressured");

	// Main outcomes that the bench should reach.
	c_pos: cover property (cnf_valid && cnf_positive && !cnf_exception);
	c_exc: cover property (cnf_valid && cnf_exception);
	c_tmo: cover property (cnf_valid && cnf_timeout);
	c_err: cover property (dem_error);
endmodule

bind tcc_client tcc_client_assertions #(.NSLOT(NSLOT), .IW(IW)) u_chk (.clk_sys, .rst,
	.max_open_client_transactions, .dem_error, .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_ready,
	.cnf_valid, .cnf_positive, .cnf_exception, .cnf_timeout, .cnf_unit, .cnf_from_serial, .open_count);

// File: tcc_srv_model.sv
`timescale 1ns/1ps
module tcc_srv_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Stall control.
	input wire logic stall_en,
	// Request stream.
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	// Response stream.
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last
);
	logic [71:0] hq[$];
	logic [63:0] hdr = 64'h0;
	logic [7:0] cnt = 8'h00;
	logic [1:0] ph = 2'h0;

	// Idle response lines at time zero.
	initial begin
		tx_ready = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
	end

	// Any unit value is accepted; header and function code of each frame are kept for the bench.
	always @(posedge clk_sys) begin
		ph <= ph + 2'h1;
		tx_ready <= #1 !(stall_en && ph == 2'h2);
		if (rst) begin
			cnt = 8'h00;
		end else if (tx_valid && tx_ready) begin
			if (cnt < 8'h08) hdr = {hdr[55:0], tx_data};
			cnt = cnt + 8'h01;
			if (tx_last) begin
				hq.push_back({hdr, cnt});
				cnt = 8'h00;
			end
		end
	end

	// Response header high byte first; length counts unit plus PDU; data byte inverted once released.
	task automatic send_rsp(input logic [15:0] tid, input logic [15:0] proto, input logic [7:0] unit,
		input logic [7:0] fc, input int nbody);
		logic [7:0] b[$];
		b = {tid[15:8], tid[7:0], proto[15:8], proto[7:0], 8'h00, 8'(nbody + 2), unit, fc};
		for (int i = 0; i < nbody; i++) b.push_back(8'(i * 37 + 5));
		foreach (b[i]) begin
			@(posedge clk_sys);
			#1;
			rx_valid = 1'b1;
			rx_data = b[i];
			rx_last = (i == b.size() - 1);
		end
		@(posedge clk_sys);
		#1;
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule

// File: tcc_client_test.sv
`timescale 1ns/1ps
module tcc_client_test import tcc_pkg::*;;
	logic clk_sys, rst, stall_en, dem_valid, dem_ready, dem_last, dem_via_gateway, dem_error;
	logic tx_valid, tx_ready, tx_last, rx_valid, rx_ready, rx_last, rsp_valid, cnf_valid;
	logic cnf_positive, cnf_exception, cnf_timeout, cnf_from_serial;
	logic [4:0] max_open_client_transactions, open_count;
	logic [31:0] timeout_cycles;
	logic [7:0] dem_data, dem_pdu_len, dem_serial_addr, tx_data, rx_data, rsp_data, cnf_fc, cnf_unit;
	logic [15:0] cnf_tid, tid_n;
	logic [71:0] exq[$];
	logic [35:0] cq[$];
	integer seed = 33450;
	int num_errors = 0, n_checks = 0, nrsp = 0, nerr = 0, rbase = 0;

	// Design and far side.
	tcc_client u_dut (.clk_sys, .rst, .max_open_client_transactions, .timeout_cycles, .dem_valid, .dem_ready,
		.dem_data, .dem_last, .dem_pdu_len, .dem_via_gateway, .dem_serial_addr, .dem_error, .tx_valid, .tx_ready,
		.tx_data, .tx_last, .rx_valid, .rx_ready, .rx_data, .rx_last, .rsp_valid, .rsp_data, .cnf_valid,
		.cnf_positive, .cnf_exception, .cnf_timeout, .cnf_tid, .cnf_fc, .cnf_unit, .cnf_from_serial, .open_count);
	tcc_srv_model u_srv (.clk_sys, .rst, .stall_en, .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_data,
		.rx_last);

	// 200 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Confirmations, PDU bytes and refusals are all single-cycle pulses, so they are collected here.
	always @(posedge clk_sys) begin
		if (cnf_valid === 1'b1) cq.push_back({cnf_tid, cnf_fc, cnf_unit, cnf_positive, cnf_exception,
			cnf_timeout, cnf_from_serial});
		if (rsp_valid === 1'b1) begin
			// Body bytes follow the far side's fixed pattern, counted from the start of this response.
			chk("pdu byte", 8'((nrsp - rbase) * 37 + 5), rsp_data);
			nrsp++;
		end
		if (dem_error === 1'b1) nerr++;
	end

	task automatic chk(input string what, input logic [71:0] e, input logic [71:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	// Expected flags {positive, exception, timeout, serial}; kind 0 good, 1 exception, 2 wrong code, 3 timeout.
	function automatic logic [3:0] flags(input int kind, input logic [7:0] unit);
		return {kind < 2, kind == 1, kind == 3, kind < 3 && unit != TCC_UNIT_DIRECT};
	endfunction

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Each byte stands until an edge samples dem_ready; valid stays up so demands can follow back to back.
	task automatic dem(input logic [7:0] fc, input int n, input logic gw, input logic [7:0] addr);
		int w;
		dem_pdu_len = 8'(n);
		dem_via_gateway = gw;
		dem_serial_addr = addr;
		for (int i = 0; i < n; i++) begin
			dem_valid = 1'b1;
			dem_data = (i == 0) ? fc : 8'($random(seed));
			dem_last = (i == n - 1);
			w = 0;
			do begin
				@(posedge clk_sys);
				w++;
			end while (dem_ready !== 1'b1 && w < 3000);
			if (w >= 3000) num_errors++;
			#1;
		end
		if (gw && addr > TCC_SERIAL_ADDR_MAX) return;
		exq.push_back({tid_n, 16'h0000, 8'h00, 8'(n + 1), gw ? addr : TCC_UNIT_DIRECT, fc, 8'(n + 7)});
		tid_n++;
	endtask

	task automatic dem_idle();
		dem_valid = 1'b0;
		dem_last = 1'b0;
	endtask

	task automatic chk_frames();
		int w;
		w = 0;
		do begin
			@(posedge clk_sys);
			w++;
		end while (u_srv.hq.size() < exq.size() && w < 1000);
		#1;
		while (exq.size() > 0) chk("frame", exq.pop_front(), u_srv.hq.pop_front());
		chk("extra frames", 0, u_srv.hq.size());
	endtask

	task automatic chk_cnf(input logic [15:0] tid, input logic [7:0] fc, input logic [7:0] unit, input logic [3:0] f);
		int w;
		w = 0;
		do begin
			@(posedge clk_sys);
			w++;
		end while (cq.size() == 0 && w < 2000);
		#1;
		chk("confirmation", {tid, fc, unit, f}, cq.pop_front());
	endtask

	// Answer one open request and check what reaches the user side.
	task automatic answer(input logic [15:0] tid, input logic [7:0] fc, input logic [7:0] unit, input int kind,
		input int nb);
		int n0;
		n0 = nrsp;
		rbase = nrsp;
		if (kind == 1) nb = 1;
		if (kind == 2) nb = 0;
		u_srv.send_rsp(tid, 16'h0000, unit, kind == 1 ? fc | TCC_EXC_FLAG : (kind == 2 ? fc ^ 8'h01 : fc), nb);
		chk_cnf(tid, fc, unit, flags(kind, unit));
		chk("pdu bytes", nb, nrsp - n0);
	endtask

	task automatic complete_run();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Cut a hang short well past the expected run length.
	initial begin
		#(5 * 60000);
		num_errors++;
		complete_run();
	end

	initial begin
		int k, kind;
		logic gw;
		logic [7:0] fcs[4], us[4];
		rst = 1'b1;
		stall_en = 1'b0;
		max_open_client_transactions = 5'h10;
		timeout_cycles = 32'h0000_012C;
		dem_valid = 1'b0;
		dem_last = 1'b0;
		dem_data = 8'h00;
		dem_pdu_len = 8'h01;
		dem_via_gateway = 1'b0;
		dem_serial_addr = 8'h00;
		tid_n = 16'h0000;
		wait_cyc(8);
		rst = 1'b0;
		// Direct, highest serial address, broadcast, then a refused address, all back to back.
		dem(8'h03, 5, 1'b0, 8'h00);
		dem(8'h10, 3, 1'b1, 8'hF7);
		dem(8'h04, 1, 1'b1, 8'h00);
		dem(8'h05, 2, 1'b1, 8'hF8);
		dem_idle();
		chk_frames();
		chk("refusals", 1, nerr);
		answer(16'h0000, 8'h03, 8'hFF, 0, 4);
		answer(16'h0001, 8'h10, 8'hF7, 1, 0);
		chk_cnf(16'h0002, 8'h04, 8'hFF, flags(3, 8'hFF));
		// Wrong protocol and unknown identifier vanish; the request then fails on a wrong code.
		dem(8'h06, 4, 1'b0, 8'h00);
		dem_idle();
		chk_frames();
		u_srv.send_rsp(16'h0003, 16'h0001, 8'hFF, 8'h06, 2);
		u_srv.send_rsp(16'h0077, 16'h0000, 8'hFF, 8'h06, 2);
		wait_cyc(20);
		chk("dropped", 0, cq.size());
		answer(16'h0003, 8'h06, 8'hFF, 2, 0);
		chk("open after", 0, open_count);
		// Limit of two: the third demand waits until a slot frees.
		max_open_client_transactions = 5'h02;
		fork
			begin
				dem(8'h01, 1, 1'b0, 8'h00);
				dem(8'h02, 2, 1'b0, 8'h00);
				dem(8'h07, 1, 1'b0, 8'h00);
				dem_idle();
			end
			begin
				wait_cyc(100);
				chk("open at cap", 2, open_count);
				chk("frames at cap", 2, u_srv.hq.size());
				answer(16'h0004, 8'h01, 8'hFF, 0, 0);
			end
		join
		chk_frames();
		answer(16'h0005, 8'h02, 8'hFF, 0, 2);
		answer(16'h0006, 8'h07, 8'hFF, 1, 0);
		// Random pipelined traffic against a stalling far side.
		max_open_client_transactions = 5'h10;
		stall_en = 1'b1;
		for (int it = 0; it < 25; it++) begin
			k = 1 + ($random(seed) & 3);
			for (int j = 0; j < k; j++) begin
				gw = $random(seed);
				fcs[j] = 8'h01 + 8'($random(seed) & 8'h7E);
				us[j] = gw ? 8'h01 + 8'($random(seed) & 8'h7F) : TCC_UNIT_DIRECT;
				dem(fcs[j], 1 + ($random(seed) & 7), gw, gw ? us[j] : 8'h00);
			end
			dem_idle();
			chk_frames();
			for (int j = 0; j < k; j++) begin
				kind = ($random(seed) & 3) % 3;
				answer(tid_n - 16'(k) + 16'(j), fcs[j], us[j], kind, $random(seed) & 3);
			end
		end
		chk("open at end", 0, open_count);
		complete_run();
	end
endmodule
